// *** ptll_line_partner.sv ***
`timescale 1ns/100ps
module ptll_line_partner
  import ptll_pkg::*;
(
  // Commands
  input wire logic want_up,
  input wire logic want_sig,
  input wire logic want_stuck,
  input wire logic [4:0] fault,
  // Monitors seen by the device
  output ptll_crit_t ll_events,
  output logic signal_present,
  output logic slicer_stuck,
  output logic link_up
);
  // No link without line signal
  assign ll_events = fault;
  assign signal_present = want_sig;
  assign slicer_stuck = want_stuck & ~want_sig;
  assign link_up = want_up & want_sig;
endmodule

// *** ptll_pkg.sv ***
package ptll_pkg;

  // Register offsets on the management port
  localparam logic [7:0] PTLL_LTC_OFS = 8'h25;
  localparam logic [7:0] PTLL_XWT_OFS = 8'h2C;
  localparam logic [7:0] PTLL_LLC_OFS = 8'h2D;
  localparam logic [7:0] PTLL_IST_OFS = 8'h40;
  localparam logic [7:0] PTLL_IMK_OFS = 8'h41;

  // Reset values
  localparam logic [15:0] PTLL_LTC_RST = 16'h0480;
  localparam logic [15:0] PTLL_XWT_RST = 16'h141F;
  localparam logic [15:0] PTLL_LLC_RST = 16'h0000;
  localparam logic [15:0] PTLL_IMK_RST = 16'h0000;

  // Line test control fields
  localparam int PTLL_LTC_PULSE_LSB = 10;
  localparam int PTLL_LTC_EXT_MSB = 9;
  localparam int PTLL_LTC_EXT_EN = 8;
  localparam int PTLL_LTC_CH_LSB = 5;
  localparam int PTLL_LTC_T10_EN = 4;
  localparam logic [15:0] PTLL_LTC_WMASK = 16'h0FFF;

  // Crossover and window timer fields
  localparam int PTLL_XWT_WIN_LSB = 9;
  localparam int PTLL_XWT_QCK_LSB = 4;
  localparam int PTLL_XWT_ROB_LSB = 0;
  localparam logic [15:0] PTLL_XWT_WMASK = 16'h3FFF;

  // Link-loss config and status fields
  localparam int PTLL_LLC_FORCE = 15;
  localparam int PTLL_LLC_BYPASS = 14;
  localparam int PTLL_LLC_STUCK = 13;
  localparam int PTLL_LLC_FLAG_LSB = 8;
  localparam logic [15:0] PTLL_LLC_WMASK = 16'hC01F;

  // Interrupt status bits: 4..0 causes, 5 crossover switched
  localparam int PTLL_IRQ_W = 6;
  localparam int PTLL_IRQ_XOVER = 5;

  // Timing
  localparam int PTLL_CLK_MHZ = 250;
  localparam int PTLL_US_NS = 1000;
  localparam int PTLL_CLK_NS = 4;
  localparam int PTLL_US_CYC = PTLL_US_NS / PTLL_CLK_NS;
  localparam int PTLL_T10_BIT_NS = 100;
  localparam int PTLL_T10_BIT_CYC = PTLL_T10_BIT_NS / PTLL_CLK_NS;
  localparam int PTLL_QCK_MS_PER_STEP = 4;
  localparam int PTLL_ROB_MS_PER_STEP = 33;

  // Rapid link-loss criteria, bit order of the select field
  typedef struct packed {
    logic sync_loss;
    logic rx_err;
    logic mlt3_err;
    logic mse_bad;
    logic energy_lost;
  } ptll_crit_t;

  // 10BASE-T test symbol on the selected channels
  typedef struct packed {
    logic active;
    logic level;
    logic tp_idle;
    logic [1:0] idle_sel;
  } ptll_line_t;

  typedef enum logic [3:0] {
    PAT_NLP, PAT_ONE, PAT_ZERO, PAT_REP1, PAT_REP0, PAT_PREAMBLE,
    PAT_ONE_IDLE, PAT_ZERO_IDLE, PAT_1001, PAT_RANDOM,
    PAT_IDLE00, PAT_IDLE01, PAT_IDLE10, PAT_IDLE11, PAT_RSV14, PAT_RSV15
  } ptll_pat_t;

endpackage

// *** ptll_regs.sv ***
`timescale 1ns/100ps
// Function
// [RL1] Channel select top bit set drives the test mode on all four channels.
// [RL2] Top bit clear drives one channel picked by low two bits, A to D.
// [RL3] Pattern bit four enables 10BASE-T tests; low four bits pick pattern.
// [RL4] Codes 0-7: NLP, pulse 1, pulse 0, rep 1, rep 0, preamble, 1/0+idle.
// [RL5] Codes 8-13: repeated 1001, random data, four idle variants.
// [RL6] Software sets low pattern bits with extension bit for 100M zero runs.
// [RL7] Window count sets the link-loss observation window, default 10us.
// [RL8] Quick crossover timer sets forced-100M switch wait, default about 4ms.
// [RL9] Robust crossover timer sets long switch interval, default about 0.5s.
// [RL10] Forced drop enable drops link and stops transmit without line signal.
// [RL11] Hold-off bypass skips the maximum wait so link drops sooner.
// [RL12] Five cause flags latch high on events and clear on register read.
// [RL13] Each criteria bit enables one link-down trigger, any combination.
// [RL14] Cause flag matches criterion index, set only if enabled and fired.
// [RL15] Reserved bits read zero, ignore writes; fields take reset values.
module ptll_regs
  import ptll_pkg::*;
#(
  parameter int US_PER_MS = 1000,
  parameter int HOLD_OFF_US = 200
)
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  output logic IRQ,
  // Line monitors
  input wire ptll_crit_t LL_EVENTS,
  input wire logic SIGNAL_PRESENT,
  input wire logic SLICER_STUCK,
  input wire logic LINK_UP,
  // Crossover control
  input wire logic QUICK_MDIX_EN,
  input wire logic ROBUST_MDIX_EN,
  output logic MDIX_SELECT,
  // Link drop
  output logic LINK_DROP,
  output logic TX_STOP,
  // Test pattern drive
  output logic [3:0] TEST_CH_EN,
  output ptll_line_t TEST_LINE,
  output logic TEST_100_EN,
  output logic [4:0] TEST_100_ZEROS,
  output logic [1:0] TEST_PULSE_SEL
);

  if (US_PER_MS < 1 || US_PER_MS > 65535 || HOLD_OFF_US < 1 ||
      HOLD_OFF_US > 65535)
  begin : g_chk
    $error("ptll_regs: timer parameter out of range");
  end

  typedef enum logic {LL_WATCH, LL_HOLD} ptll_ll_t;

  // Scale a timer field to a nonzero step count
  function automatic logic [15:0] steps(input logic [4:0] val,
                                        input logic [5:0] per);
    logic [10:0] p;
    p = {6'h00, (val == 5'h00) ? 5'h01 : val} * {5'h00, per};
    steps = {5'h00, p};
  endfunction

  logic [15:0] ltc_r, xwt_r;
  logic [1:0] llc_ctl_r;
  logic [4:0] llc_crit_r, flags_r;
  logic [PTLL_IRQ_W-1:0] ist_r, imk_r;
  logic [15:0] rdata_r;
  logic [7:0] us_cnt_r;
  logic [15:0] ms_cnt_r, mdix_cnt_r, hold_cnt_r;
  logic [4:0] win_cnt_r, hits_r;
  ptll_ll_t ll_state_r;
  logic mdix_r, drop_r;
  logic [4:0] t10_cnt_r;
  logic [1:0] phase_r;
  logic sent_r;
  logic [6:0] lfsr_r;
  ptll_line_t line_r;
  logic [3:0] ch_r;

  // Address decode
  wire sel_ltc = (REG_ADDR == PTLL_LTC_OFS);
  wire sel_xwt = (REG_ADDR == PTLL_XWT_OFS);
  wire sel_llc = (REG_ADDR == PTLL_LLC_OFS);
  wire sel_ist = (REG_ADDR == PTLL_IST_OFS);
  wire sel_imk = (REG_ADDR == PTLL_IMK_OFS);
  wire wr_ltc = REG_WR && sel_ltc;
  wire rd_llc = REG_RD && sel_llc;

  // Register fields
  wire [2:0] ch_sel = ltc_r[PTLL_LTC_CH_LSB +: 3];
  wire t10_en = ltc_r[PTLL_LTC_T10_EN]; // [RL3]
  wire ptll_pat_t pat = ptll_pat_t'(ltc_r[3:0]);
  wire [4:0] win_val = xwt_r[PTLL_XWT_WIN_LSB +: 5];
  wire [4:0] qck_val = xwt_r[PTLL_XWT_QCK_LSB +: 5];
  wire [4:0] rob_val = {1'b0, xwt_r[PTLL_XWT_ROB_LSB +: 4]};
  wire force_en = llc_ctl_r[1];
  wire bypass = llc_ctl_r[0];

  logic [15:0] rd_mux;
  always_comb
  begin
    rd_mux = 16'h0000;
    if (sel_ltc)
      rd_mux = ltc_r;
    else if (sel_xwt)
      rd_mux = xwt_r;
    else if (sel_llc)
      rd_mux = {force_en, bypass, SLICER_STUCK, flags_r, 3'h0, llc_crit_r};
    else if (sel_ist)
      rd_mux = {{(16-PTLL_IRQ_W){1'b0}}, ist_r};
    else if (sel_imk)
      rd_mux = {{(16-PTLL_IRQ_W){1'b0}}, imk_r};
  end

  // Timebase: microsecond and millisecond enables
  wire us_tick = (us_cnt_r == 8'(PTLL_US_CYC - 1));
  wire ms_tick = us_tick && (ms_cnt_r == 16'(US_PER_MS - 1));
  wire t10_tick = (t10_cnt_r == 5'(PTLL_T10_BIT_CYC - 1));

  // Rapid link-loss evaluation
  wire ptll_crit_t hit_now = LL_EVENTS & llc_crit_r; // [RL13]
  wire [4:0] hits_all = hits_r | hit_now;
  wire [4:0] win_lim = (win_val == 5'h00) ? 5'h01 : win_val;
  wire win_end = us_tick && (win_cnt_r >= win_lim - 5'h01); // [RL7]
  wire hold_end = us_tick && (hold_cnt_r == 16'(HOLD_OFF_US - 1));
  logic fld_fire;
  always_comb
  begin
    fld_fire = 1'b0;
    case (ll_state_r)
      LL_WATCH: fld_fire = LINK_UP && win_end && (hits_all != 5'h00) &&
                           bypass; // [RL11]
      LL_HOLD: fld_fire = hold_end;
      default: fld_fire = 1'b0;
    endcase
  end
  wire [4:0] flag_set = !fld_fire ? 5'h00 : // [RL14]
    (ll_state_r == LL_HOLD) ? hits_r : hits_all;
  wire no_signal_drop = force_en && !SIGNAL_PRESENT; // [RL10]

  // Crossover switching
  wire mdix_on = (QUICK_MDIX_EN || ROBUST_MDIX_EN) && !LINK_UP;
  wire [15:0] mdix_lim = QUICK_MDIX_EN ?
    steps(qck_val, 6'(PTLL_QCK_MS_PER_STEP)) : // [RL8]
    steps(rob_val, 6'(PTLL_ROB_MS_PER_STEP)); // [RL9]
  wire mdix_flip = mdix_on && ms_tick && (mdix_cnt_r >= mdix_lim - 16'h1);

  wire [PTLL_IRQ_W-1:0] ev = {mdix_flip, flag_set};

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      ltc_r <= PTLL_LTC_RST; // [RL15]
      xwt_r <= PTLL_XWT_RST;
      llc_ctl_r <= PTLL_LLC_RST[15:14];
      llc_crit_r <= PTLL_LLC_RST[4:0];
      imk_r <= PTLL_IMK_RST[PTLL_IRQ_W-1:0];
    end
    else if (REG_WR)
    begin
      // Only writable bits are kept; reserved bits stay zero
      if (sel_ltc)
        ltc_r <= REG_WDATA & PTLL_LTC_WMASK; // [RL15]
      if (sel_xwt)
        xwt_r <= REG_WDATA & PTLL_XWT_WMASK;
      if (sel_llc)
      begin
        llc_ctl_r <= REG_WDATA[PTLL_LLC_FORCE -: 2];
        llc_crit_r <= REG_WDATA[4:0] & PTLL_LLC_WMASK[4:0];
      end
      if (sel_imk)
        imk_r <= REG_WDATA[PTLL_IRQ_W-1:0];
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      flags_r <= 5'h00;
      rdata_r <= 16'h0000;
      drop_r <= 1'b0;
      mdix_r <= 1'b0;
    end
    else
    begin
      flags_r <= (rd_llc ? 5'h00 : flags_r) | flag_set; // [RL12]
      rdata_r <= REG_RD ? rd_mux : 16'h0000;
      drop_r <= fld_fire || no_signal_drop; // [RL10]
      if (mdix_flip)
        mdix_r <= !mdix_r;
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      ist_r <= '0;
    else if (REG_WR && sel_ist)
      ist_r <= (ist_r & ~REG_WDATA[PTLL_IRQ_W-1:0]) | ev;
    else
      ist_r <= ist_r | ev;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      us_cnt_r <= 8'h00;
      ms_cnt_r <= 16'h0000;
    end
    else
    begin
      us_cnt_r <= us_tick ? 8'h00 : us_cnt_r + 8'h01;
      if (ms_tick)
        ms_cnt_r <= 16'h0000;
      else if (us_tick)
        ms_cnt_r <= ms_cnt_r + 16'h0001;
    end
  end

  // Window restarts each period; hits gather across it
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N || !LINK_UP)
    begin
      win_cnt_r <= 5'h00;
      hits_r <= 5'h00;
      hold_cnt_r <= 16'h0000;
      ll_state_r <= LL_WATCH;
    end
    else
    begin
      case (ll_state_r)
        LL_WATCH:
        begin
          if (win_end)
          begin
            win_cnt_r <= 5'h00;
            hits_r <= 5'h00;
            if (hits_all != 5'h00 && !bypass)
            begin
              hits_r <= hits_all;
              ll_state_r <= LL_HOLD;
            end
          end
          else
          begin
            hits_r <= hits_all;
            if (us_tick)
              win_cnt_r <= win_cnt_r + 5'h01;
          end
        end
        LL_HOLD:
        begin
          // Hold-off delays the drop; it fires at hold_end even if no event recurs
          if (hold_end)
          begin
            hold_cnt_r <= 16'h0000;
            hits_r <= 5'h00;
            ll_state_r <= LL_WATCH;
          end
          else if (us_tick)
            hold_cnt_r <= hold_cnt_r + 16'h0001;
        end
        default: ll_state_r <= LL_WATCH;
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N || !mdix_on)
      mdix_cnt_r <= 16'h0000;
    else if (mdix_flip)
      mdix_cnt_r <= 16'h0000;
    else if (ms_tick)
      mdix_cnt_r <= mdix_cnt_r + 16'h0001;
  end

  // Channel steering
  wire [3:0] ch_nxt = ch_sel[2] ? 4'hF : // [RL1]
                      (4'h1 << ch_sel[1:0]); // [RL2]
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      ch_r <= 4'h0;
    else
      ch_r <= t10_en ? ch_nxt : 4'h0;
  end

  // 10BASE-T pattern engine, one bit per 100ns; a write restarts singles
  wire pat_bit_1001 = (phase_r == 2'h0) || (phase_r == 2'h3);
  wire [1:0] sel_nxt = (pat >= PAT_IDLE00 && pat <= PAT_IDLE11) ?
    ltc_r[1:0] - 2'h2 : 2'h0;
  logic [1:0] act_lvl;
  logic idle_nxt;
  always_comb
  begin
    act_lvl = 2'b00;
    idle_nxt = 1'b0;
    case (pat) // [RL4]
      PAT_NLP, PAT_ONE, PAT_ZERO: act_lvl = sent_r ? 2'b00 : {1'b1, !ltc_r[1]};
      PAT_REP1: act_lvl = 2'b11;
      PAT_REP0: act_lvl = 2'b10;
      PAT_PREAMBLE: act_lvl = {1'b1, !phase_r[0]};
      PAT_ONE_IDLE, PAT_ZERO_IDLE:
      begin
        act_lvl = sent_r ? 2'b00 : {1'b1, !ltc_r[0]};
        idle_nxt = sent_r;
      end
      PAT_1001: act_lvl = {1'b1, pat_bit_1001}; // [RL5]
      PAT_RANDOM: act_lvl = {1'b1, lfsr_r[0]};
      PAT_IDLE00, PAT_IDLE01, PAT_IDLE10, PAT_IDLE11: idle_nxt = 1'b1;
      default: act_lvl = 2'b00;
    endcase
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N || !t10_en || wr_ltc)
    begin
      t10_cnt_r <= 5'h00;
      phase_r <= 2'h0;
      sent_r <= 1'b0;
      lfsr_r <= 7'h7F;
      line_r <= '0;
    end
    else
    begin
      t10_cnt_r <= t10_tick ? 5'h00 : t10_cnt_r + 5'h01;
      if (t10_tick)
      begin
        phase_r <= phase_r + 2'h1;
        sent_r <= 1'b1;
        lfsr_r <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
        line_r <= '{active: act_lvl[1], level: act_lvl[0],
                    tp_idle: idle_nxt, idle_sel: sel_nxt};
      end
    end
  end

  // 100M extended test: the zero count comes from software
  assign TEST_100_EN = ltc_r[PTLL_LTC_EXT_EN] && !t10_en;
  assign TEST_100_ZEROS = {ltc_r[PTLL_LTC_EXT_MSB], ltc_r[3:0]}; // [RL6]
  assign TEST_PULSE_SEL = ltc_r[PTLL_LTC_PULSE_LSB +: 2];
  assign TEST_CH_EN = ch_r;
  assign TEST_LINE = line_r;
  assign REG_RDATA = rdata_r;
  assign IRQ = |(ist_r & imk_r);
  assign MDIX_SELECT = mdix_r;
  assign LINK_DROP = drop_r;
  assign TX_STOP = drop_r;

endmodule

// *** ptll_regs_assertions.sv ***
`timescale 1ns/100ps
module ptll_regs_assertions
  import ptll_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic IRQ,
  // Line and outputs
  input wire logic SIGNAL_PRESENT,
  input wire logic LINK_UP,
  input wire logic QUICK_MDIX_EN,
  input wire logic ROBUST_MDIX_EN,
  input wire logic MDIX_SELECT,
  input wire logic LINK_DROP,
  input wire logic TX_STOP,
  input wire logic [3:0] TEST_CH_EN,
  input wire logic TEST_100_EN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  logic [15:0] rsv;
  // Unmapped places read as all reserved
  assign rsv = REG_ADDR == PTLL_LTC_OFS ? 16'hF000 :
    REG_ADDR == PTLL_XWT_OFS ? 16'hC000 :
    REG_ADDR == PTLL_LLC_OFS ? 16'h00E0 :
    REG_ADDR inside {PTLL_IST_OFS, PTLL_IMK_OFS} ? 16'hFFC0 : 16'hFFFF;
  chk_read_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0)
    else $error("read data not idle");
  chk_reserved_zero: assert property
    (REG_RD |=> (REG_RDATA & $past(rsv)) == 16'h0)
    else $error("reserved bits not zero");
  chk_drop_tx: assert property (LINK_DROP == TX_STOP)
    else $error("drop and stop differ");
  chk_channel_code: assert property
    (TEST_CH_EN inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hF})
    else $error("bad channel enables");
  chk_irq_cause: assert property ($rose(IRQ) |->
    $past(REG_WR) || LINK_DROP || $changed(MDIX_SELECT))
    else $error("interrupt without cause");
  chk_mdix_hold: assert property
    ($past(LINK_UP || !(QUICK_MDIX_EN || ROBUST_MDIX_EN))
    |-> $stable(MDIX_SELECT))
    else $error("crossover moved while idle");
  chk_drop_cause: assert property
    ($rose(LINK_DROP) |-> $past(!SIGNAL_PRESENT || LINK_UP))
    else $error("drop without cause");
  chk_fast_ch_off: assert property
    (TEST_100_EN && $past(TEST_100_EN) |-> TEST_CH_EN == 4'h0)
    else $error("channels on in 100M test");
  cov_drop: cover property ($rose(LINK_DROP));
  cov_mdix: cover property ($changed(MDIX_SELECT));
  cov_irq: cover property ($rose(IRQ));
endmodule

// *** ptll_regs_tb.sv ***
`timescale 1ns/100ps
module ptll_regs_tb
  import ptll_pkg::*;
;
  localparam int QCK = PTLL_QCK_MS_PER_STEP * 4 * PTLL_US_CYC;
  localparam int ROB = PTLL_ROB_MS_PER_STEP * 4 * PTLL_US_CYC;
  localparam int MS = 4 * PTLL_US_CYC;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'h0;
  logic rd_s = 1'h0;
  logic quick = 1'h0;
  logic robust = 1'h0;
  logic up = 1'h0;
  logic sig = 1'h1;
  logic stk = 1'h0;
  logic [4:0] fault = 5'h00;
  logic [15:0] rdata;
  logic irq, mdix, drop, txs, t100, sp, ss, lu;
  logic [3:0] ch;
  logic [4:0] zeros;
  logic [1:0] psel;
  ptll_line_t line;
  ptll_crit_t ev_w;
  int errors = 0;
  int tests_run = 0;
  int seed = 85425;
  always #2 clock = ~clock;
  ptll_regs #(.US_PER_MS(4), .HOLD_OFF_US(2)) i_dut (.CLOCK(clock),
    .RESET_N(reset_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s),
    .REG_RD(rd_s), .REG_RDATA(rdata), .IRQ(irq), .LL_EVENTS(ev_w),
    .SIGNAL_PRESENT(sp), .SLICER_STUCK(ss), .LINK_UP(lu),
    .QUICK_MDIX_EN(quick), .ROBUST_MDIX_EN(robust), .MDIX_SELECT(mdix),
    .LINK_DROP(drop), .TX_STOP(txs), .TEST_CH_EN(ch), .TEST_LINE(line),
    .TEST_100_EN(t100), .TEST_100_ZEROS(zeros), .TEST_PULSE_SEL(psel));
  ptll_line_partner i_partner (.want_up(up), .want_sig(sig),
    .want_stuck(stk), .fault(fault), .ll_events(ev_w),
    .signal_present(sp), .slicer_stuck(ss), .link_up(lu));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge clock);
    wr_s <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge clock);
    rd_s <= 1'h0;
    #1;
    d = rdata;
  endtask
  task automatic chk(input string s, input logic [15:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_sig(input logic m, input int lim, output int n);
    logic s;
    s = mdix;
    n = 0;
    while ((m ? drop !== 1'h1 : mdix === s) && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  // Mask in the upper half, steady symbol in the lower
  function automatic logic [9:0] exp_line(input logic [3:0] p);
    case (p)
      4'h3: return {5'h1F, 5'h18};
      4'h4: return {5'h1F, 5'h10};
      4'h6, 4'h7: return {5'h04, 5'h04};
      4'h5, 4'h8, 4'h9: return {5'h10, 5'h10};
      4'hA, 4'hB, 4'hC, 4'hD: return {5'h07, 3'h1, 2'(p - 4'hA)};
      default: return {5'h10, 5'h00};
    endcase
  endfunction
  initial
  begin
    repeat (60000) @(posedge clock);
    errors++;
    end_of_test();
  end
  initial
  begin
    logic [15:0] d, r;
    logic [4:0] cr, ev;
    logic [9:0] el;
    int n;
    cyc(4);
    reset_n <= 1'h1;
    cyc(1);
    rd(PTLL_LTC_OFS, d);
    chk("test ctrl", 16'h0480, d);
    rd(PTLL_XWT_OFS, d);
    chk("timers", 16'h141F, d);
    rd(PTLL_LLC_OFS, d);
    chk("loss cfg", 16'h0000, d);
    for (int i = 0; i < 4; i++)
    begin
      d = $random(seed);
      wr(PTLL_XWT_OFS, d);
      rd(PTLL_XWT_OFS, r);
      chk("timers rw", d & 16'h3FFF, r);
      wr(PTLL_LLC_OFS, d);
      rd(PTLL_LLC_OFS, r);
      chk("loss rw", d & 16'hC01F, r);
      wr(8'h30, d);
      rd(8'h30, r);
      chk("unmapped", 16'h0000, r);
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(PTLL_LTC_OFS, 16'h0013 | 16'(c << 5));
      cyc(1);
      chk("channels", c > 3 ? 4'hF : 4'h1 << c, ch);
    end
    for (int p = 0; p < 16; p++)
    begin
      wr(PTLL_LTC_OFS, 16'h0090 | 16'(p));
      cyc(60);
      el = exp_line(4'(p));
      chk("pattern", el[4:0], line & el[9:5]);
    end
    wr(PTLL_LTC_OFS, 16'h0B05);
    cyc(1);
    chk("100M", 16'h8415, {t100, ch, psel, 4'h0, zeros});
    wr(PTLL_XWT_OFS, 16'h0201);
    up <= 1'h1;
    for (int b = 1; b >= 0; b--)
    begin
      cr = $random(seed) | 1;
      ev = $random(seed) | 1;
      wr(PTLL_IMK_OFS, b ? 16'h003F : 16'h0000);
      wr(PTLL_LLC_OFS, 16'(b << 14) | cr);
      fault <= ev;
      cyc(1);
      fault <= 5'h00;
      wait_sig(1'h1, 1500, n);
      chk("drop time", 16'h1, b ? n < 300 : n >= 500 && n < 800);
      rd(PTLL_LLC_OFS, d);
      chk("causes", cr & ev, d[12:8]);
      chk("irq", b, irq);
      rd(PTLL_LLC_OFS, d);
      chk("causes cleared", 16'h0, d[12:8]);
      wr(PTLL_IST_OFS, 16'h003F);
    end
    rd(PTLL_IST_OFS, d);
    chk("status cleared", 16'h0, d);
    chk("irq cleared", 16'h0, irq);
    wr(PTLL_LLC_OFS, 16'h8000);
    sig <= 1'h0;
    stk <= 1'h1;
    cyc(3);
    chk("forced drop", 16'h3, {drop, txs});
    rd(PTLL_LLC_OFS, d);
    chk("stuck", 16'hA000, d);
    sig <= 1'h1;
    cyc(3);
    chk("drop release", 16'h0, {drop, txs});
    up <= 1'h0;
    quick <= 1'h1;
    wait_sig(1'h0, 2 * QCK, n);
    chk("quick", 16'h1, n > QCK - MS && n < QCK + 10);
    rd(PTLL_IST_OFS, d);
    chk("switch status", 16'h0020, d & 16'h0020);
    quick <= 1'h0;
    cyc(1);
    robust <= 1'h1;
    wait_sig(1'h0, 2 * ROB, n);
    chk("robust", 16'h1, n > ROB - MS && n < ROB + 10);
    robust <= 1'h0;
    reset_n <= 1'h0;
    cyc(2);
    reset_n <= 1'h1;
    cyc(1);
    rd(PTLL_LTC_OFS, d);
    chk("ctrl after reset", 16'h0480, d);
    chk("pulse sel", 16'h1, psel);
    end_of_test();
  end
endmodule
bind ptll_regs ptll_regs_assertions i_chk (.CLOCK(CLOCK),
  .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ),
  .SIGNAL_PRESENT(SIGNAL_PRESENT), .LINK_UP(LINK_UP),
  .QUICK_MDIX_EN(QUICK_MDIX_EN), .ROBUST_MDIX_EN(ROBUST_MDIX_EN),
  .MDIX_SELECT(MDIX_SELECT), .LINK_DROP(LINK_DROP), .TX_STOP(TX_STOP),
  .TEST_CH_EN(TEST_CH_EN), .TEST_100_EN(TEST_100_EN));
